// *** rtl/igr_pkg.sv ***
/*
 * Constants shared by the interrupt group routing block: register
 * offsets, control field positions, reset values and special IDs.
 * Assumes a 32-bit classic Wishbone register bus with byte addresses.
 */
package igr_pkg;

  // ************************************************************
  // Geometry
  // ************************************************************
  localparam int ADDR_W = 14;
  localparam int ID_W   = 10;
  localparam int PRIO_W = 8;

  // ************************************************************
  // Register offsets (byte addresses)
  // ************************************************************
  localparam logic [ADDR_W-1:0] OFS_DIST_CTRL  = 14'h0000;
  localparam logic [ADDR_W-1:0] OFS_GROUP      = 14'h0080;
  localparam logic [ADDR_W-1:0] OFS_ENABLE     = 14'h0100;
  localparam logic [ADDR_W-1:0] OFS_PRIO       = 14'h0400;
  localparam logic [ADDR_W-1:0] OFS_CPU_CTRL   = 14'h2000;
  localparam logic [ADDR_W-1:0] OFS_PRIO_MASK  = 14'h2004;
  localparam logic [ADDR_W-1:0] OFS_BIN_PT     = 14'h2008;
  localparam logic [ADDR_W-1:0] OFS_ACK        = 14'h200c;
  localparam logic [ADDR_W-1:0] OFS_EOI        = 14'h2010;
  localparam logic [ADDR_W-1:0] OFS_RUN_PRIO   = 14'h2014;
  localparam logic [ADDR_W-1:0] OFS_HP_PEND    = 14'h2018;
  localparam logic [ADDR_W-1:0] OFS_ABIN_PT    = 14'h201c;
  localparam logic [ADDR_W-1:0] OFS_AACK       = 14'h2020;
  localparam logic [ADDR_W-1:0] OFS_AEOI       = 14'h2024;
  localparam logic [ADDR_W-1:0] OFS_VLIST      = 14'h2040;
  localparam logic [ADDR_W-1:0] OFS_INT_STAT   = 14'h2044;
  localparam logic [ADDR_W-1:0] OFS_INT_MASK   = 14'h2048;

  // ************************************************************
  // Control fields
  // ************************************************************
  localparam int CTL_GRP0_EN  = 0;
  localparam int CTL_GRP1_EN  = 1;
  localparam int CTL_ACK_CTL  = 2;
  localparam int CTL_FAST_SEL = 3;
  localparam int CTL_CBP      = 4;
  localparam int CTL_W        = 5;
  localparam int VL_PEND      = 0;
  localparam int VL_FAST      = 1;
  localparam int ST_SPURIOUS  = 0;
  localparam int ST_BAD_EOI   = 1;

  // ************************************************************
  // Reset values and special IDs
  // ************************************************************
  localparam logic [2:0]        BIN_PT_RST  = 3'h2;
  localparam logic [2:0]        ABIN_PT_RST = 3'h3;
  localparam logic [PRIO_W-1:0] IDLE_PRIO   = 8'hff;
  localparam logic [ID_W-1:0]   ID_SPURIOUS = 10'h3ff;
  localparam logic [ID_W-1:0]   ID_WRONG_GRP = 10'h3fe;

endpackage

// *** rtl/igr_sync.sv ***
/*
 * Two-stage synchroniser for a vector of asynchronous level inputs.
 * Assumes each bit is an independent level; no bus coherency.
 */
`timescale 1ns/1ps
module igr_sync #(
  parameter int W = 32
) (
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule

// *** rtl/igr_pick.sv ***
/*
 * Picks the highest-priority request (lowest value, then lowest ID)
 * out of a request vector, with per-group enables.
 * Assumes N fits in the ID width of the package.
 */
`timescale 1ns/1ps
module igr_pick
  import igr_pkg::*;
#(
  parameter int N = 32
) (
  input  wire logic [N-1:0]            req_i,
  input  wire logic [N-1:0]            grp0_i,
  input  wire logic [igr_pkg::PRIO_W-1:0] prio_i [N],
  input  wire logic                    en0_i,
  input  wire logic                    en1_i,
  output logic                         valid_o,
  output logic [igr_pkg::ID_W-1:0]     id_o,
  output logic                         grp0_o,
  output logic [igr_pkg::PRIO_W-1:0]   prio_o
);

  // Linear scan; strict compare keeps the lowest ID on a tie
  always_comb begin
    valid_o = 1'b0;
    id_o    = ID_SPURIOUS;
    grp0_o  = 1'b0;
    prio_o  = IDLE_PRIO;
    for (int i = 0; i < N; i++) begin
      if (req_i[i] && (grp0_i[i] ? en0_i : en1_i) &&
          (!valid_o || prio_i[i] < prio_o)) begin
        valid_o = 1'b1;
        id_o    = ID_W'(i);
        grp0_o  = grp0_i[i];
        prio_o  = prio_i[i];
      end
    end
  end

endmodule

// *** rtl/igr_top.sv ***
/*
 * Per-processor interrupt group routing: distributor group state,
 * CPU interface control, acknowledge/completion registers and the
 * fast and normal request lines, behind a classic Wishbone slave.
 * Assumes level interrupt sources asynchronous to clk_i, NUM_IRQ a
 * multiple of 4 and at most 32, and one processor on the request lines.
 */
// Functional notes
// - After reset every interrupt sits in group zero.
// - Software moves each interrupt to group zero or one; group one goes to the normal line.
// - With the fast-select bit set, group zero uses the fast line instead of the normal line.
// - The distributor has separate enables and forwards a group only while it is enabled.
// - The CPU interface has separate enables and signals a group only while it is enabled.
// - With acknowledge control 0, the primary read takes group zero and the alias takes group one.
// - With acknowledge control 0, the primary write ends group zero and the alias ends group one.
// - Acknowledge control 1 selects the older mode where the primary registers serve both groups.
// - With common binary point 0, group zero uses the primary and group one the aliased point.
// - With common binary point 1, the primary binary point serves both groups.
// - A virtual list entry is presented to the guest as a virtual fast or normal request.
`timescale 1ns/1ps
module igr_top
  import igr_pkg::*;
#(
  parameter int NUM_IRQ = 32
) (
  input  wire logic                        clk_i,
  input  wire logic                        sys_rst_i,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [igr_pkg::ADDR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [31:0]                 wb_dat_i,
  output logic      [31:0]                 wb_dat_o,
  output logic                             wb_ack_o,
  input  wire logic [NUM_IRQ-1:0]          irq_src_i,
  output logic                             fast_irq_request_n_o,
  output logic                             normal_irq_request_n_o,
  output logic                             virtual_fast_request_o,
  output logic                             virtual_normal_request_o,
  output logic                             irq_o
);
  import igr_pkg::*;

  localparam int PW = $clog2(NUM_IRQ);

  // ************************************************************
  // State
  // ************************************************************
  logic [1:0]         dist_ctrl_r;
  logic [NUM_IRQ-1:0] grp_assign_r;
  logic [NUM_IRQ-1:0] enable_r;
  logic [NUM_IRQ-1:0] active_r;
  logic [PRIO_W-1:0]  prio_r [NUM_IRQ];
  logic [CTL_W-1:0]   cpu_ctrl_r;
  logic [PRIO_W-1:0]  prio_mask_r;
  logic [2:0]         bin_pt_r;
  logic [2:0]         abin_pt_r;
  logic [1:0]         vlist_r;
  logic [1:0]         stat_r;
  logic [1:0]         mask_r;
  logic [1:0]         stat_nxt;
  logic [31:0]        rd_nxt;
  logic [NUM_IRQ-1:0] src_sync;

  // ************************************************************
  // Binary point to group-priority mask
  // ************************************************************
  // Group one shifts one place less, so it can split one finer
  function automatic logic [PRIO_W-1:0] bp_mask(input logic [2:0] bp,
                                                input logic       grp1);
    logic [3:0] sh;
    sh = grp1 ? {1'b0, bp} : 4'({1'b0, bp} + 4'h1);
    return PRIO_W'(9'h0ff << sh);
  endfunction

  // ************************************************************
  // Source synchronisers and priority pickers
  // ************************************************************
  igr_sync #(.W(NUM_IRQ)) u_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (irq_src_i),
    .sync_o    (src_sync)
  );

  logic              hp_valid;
  logic [ID_W-1:0]   hp_id;
  logic              hp_grp0;
  logic [PRIO_W-1:0] hp_prio;
  logic              act_any;
  logic [PRIO_W-1:0] run_prio;

  igr_pick #(.N(NUM_IRQ)) u_pend (
    .req_i   (src_sync & enable_r & ~active_r),
    .grp0_i  (~grp_assign_r),
    .prio_i  (prio_r),
    .en0_i   (dist_ctrl_r[CTL_GRP0_EN]),
    .en1_i   (dist_ctrl_r[CTL_GRP1_EN]),
    .valid_o (hp_valid),
    .id_o    (hp_id),
    .grp0_o  (hp_grp0),
    .prio_o  (hp_prio)
  );

  // Running priority is the best priority among active interrupts
  igr_pick #(.N(NUM_IRQ)) u_run (
    .req_i   (active_r),
    .grp0_i  (~grp_assign_r),
    .prio_i  (prio_r),
    .en0_i   (1'b1),
    .en1_i   (1'b1),
    .valid_o (act_any),
    .id_o    (),
    .grp0_o  (),
    .prio_o  (run_prio)
  );

  // ************************************************************
  // Exception generation
  // ************************************************************
  wire ack_ctl  = cpu_ctrl_r[CTL_ACK_CTL];
  wire fast_sel = cpu_ctrl_r[CTL_FAST_SEL];
  wire cpu_en0  = cpu_ctrl_r[CTL_GRP0_EN];
  wire cpu_en1  = cpu_ctrl_r[CTL_GRP1_EN];

  // separate points per group when common point is clear
  // common point makes the primary point serve group one
  wire [PRIO_W-1:0] mask_g0 = bp_mask(bin_pt_r, 1'b0);
  wire [PRIO_W-1:0] mask_g1 = cpu_ctrl_r[CTL_CBP] ? mask_g0 : bp_mask(abin_pt_r, 1'b1);
  wire [PRIO_W-1:0] grp_mask = hp_grp0 ? mask_g0 : mask_g1;

  // Only a pending interrupt that beats the mask and preempts counts
  wire next_int = hp_valid && (hp_prio < prio_mask_r) &&
                  (!act_any || hp_prio < (run_prio & grp_mask));

  // fast line for group zero when selected
  wire fast_nxt = next_int && hp_grp0 && fast_sel && cpu_en0;
  // group one, and group zero without fast select, use normal line
  // CPU interface enables gate signalling per group
  wire norm_nxt = next_int && !(hp_grp0 && fast_sel) &&
                  (hp_grp0 ? cpu_en0 : cpu_en1);

  // ************************************************************
  // Bus decode
  // ************************************************************
  wire acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr  = acc && wb_we_i;
  wire rd  = acc && !wb_we_i;

  wire [ADDR_W-1:0] adr     = {wb_adr_i[ADDR_W-1:2], 2'b00};
  wire [ADDR_W-1:0] prio_of = ADDR_W'(adr - OFS_PRIO);
  wire              hit_prio = (adr >= OFS_PRIO) &&
                               (prio_of < ADDR_W'(NUM_IRQ));
  wire [PW-1:0]     prio_base = prio_of[PW-1:0];
  wire [31:0]       prio_word = {prio_r[PW'(prio_base + PW'(3))],
                                 prio_r[PW'(prio_base + PW'(2))],
                                 prio_r[PW'(prio_base + PW'(1))],
                                 prio_r[prio_base]};

  // primary read takes group zero unless the older mode is on
  // older mode lets the primary registers serve both groups
  wire rd_ack   = rd && adr == OFS_ACK;
  wire rd_aack  = rd && adr == OFS_AACK;
  wire ack_ok   = rd_ack ? (hp_grp0 || ack_ctl) : !hp_grp0;
  wire ack_take = (rd_ack || rd_aack) && next_int && ack_ok;
  wire [ID_W-1:0] ack_id = ack_take ? hp_id :
                           (rd_ack && next_int && !hp_grp0) ? ID_WRONG_GRP :
                           ID_SPURIOUS;

  // primary write ends group zero, alias ends group one
  wire            wr_eoi  = wr && adr == OFS_EOI;
  wire            wr_aeoi = wr && adr == OFS_AEOI;
  wire [ID_W-1:0] eoi_id  = wb_dat_i[ID_W-1:0];
  wire [PW-1:0]   eoi_ix  = eoi_id[PW-1:0];
  wire            eoi_in  = eoi_id < ID_W'(NUM_IRQ);
  wire            eoi_grp = wr_eoi ? (!grp_assign_r[eoi_ix] || ack_ctl)
                                   : grp_assign_r[eoi_ix];
  wire            eoi_ok  = (wr_eoi || wr_aeoi) && eoi_in &&
                            active_r[eoi_ix] && eoi_grp;

  // Read data selection; unmapped addresses read as zero
  assign rd_nxt =
    adr == OFS_DIST_CTRL ? 32'(dist_ctrl_r) :
    adr == OFS_GROUP     ? 32'(grp_assign_r) :
    adr == OFS_ENABLE    ? 32'(enable_r) :
    hit_prio             ? prio_word :
    adr == OFS_CPU_CTRL  ? 32'(cpu_ctrl_r) :
    adr == OFS_PRIO_MASK ? 32'(prio_mask_r) :
    adr == OFS_BIN_PT    ? 32'(bin_pt_r) :
    adr == OFS_ABIN_PT   ? 32'(abin_pt_r) :
    (rd_ack || rd_aack)  ? 32'(ack_id) :
    adr == OFS_RUN_PRIO  ? 32'(act_any ? run_prio : IDLE_PRIO) :
    adr == OFS_HP_PEND   ? 32'(hp_valid ? hp_id : ID_SPURIOUS) :
    adr == OFS_VLIST     ? 32'(vlist_r) :
    adr == OFS_INT_STAT  ? 32'(stat_r) :
    adr == OFS_INT_MASK  ? 32'(mask_r) : 32'h0000_0000;

  // Events set sticky bits; a set in the clearing cycle wins
  wire [1:0] ev_set = {wr && (wr_eoi || wr_aeoi) && !eoi_ok,
                       (rd_ack || rd_aack) && !ack_take};
  wire [1:0] ev_clr = (wr && adr == OFS_INT_STAT && wb_sel_i[0]) ?
                      wb_dat_i[1:0] : 2'b00;
  assign stat_nxt = (stat_r & ~ev_clr) | ev_set;

  // ************************************************************
  // Bus answer: one-cycle registered acknowledge
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= acc;
      wb_dat_o <= rd ? rd_nxt : 32'h0000_0000;
    end
  end

  // ************************************************************
  // Distributor registers
  // ************************************************************
  // all interrupts come out of reset in group zero
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      dist_ctrl_r  <= 2'h0;
      grp_assign_r <= '0;
      enable_r     <= '0;
    end else if (wr && wb_sel_i[0]) begin
      if (adr == OFS_DIST_CTRL)
        dist_ctrl_r <= wb_dat_i[1:0];
      if (adr == OFS_GROUP)
        grp_assign_r <= wb_dat_i[NUM_IRQ-1:0];
      if (adr == OFS_ENABLE)
        enable_r <= wb_dat_i[NUM_IRQ-1:0];
    end
  end

  // Priority bytes, one lane per byte select
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < NUM_IRQ; i++)
        prio_r[i] <= 8'h00;
    end else if (wr && hit_prio) begin
      for (int b = 0; b < 4; b++)
        if (wb_sel_i[b])
          prio_r[PW'(prio_base + PW'(b))] <= wb_dat_i[8*b +: 8];
    end
  end

  // ************************************************************
  // CPU interface registers and active state
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cpu_ctrl_r  <= '0;
      prio_mask_r <= 8'h00;
      bin_pt_r    <= BIN_PT_RST;
      abin_pt_r   <= ABIN_PT_RST;
      vlist_r     <= 2'h0;
      mask_r      <= 2'h0;
    end else if (wr && wb_sel_i[0]) begin
      if (adr == OFS_CPU_CTRL)
        cpu_ctrl_r <= wb_dat_i[CTL_W-1:0];
      if (adr == OFS_PRIO_MASK)
        prio_mask_r <= wb_dat_i[PRIO_W-1:0];
      if (adr == OFS_BIN_PT)
        bin_pt_r <= wb_dat_i[2:0];
      if (adr == OFS_ABIN_PT)
        abin_pt_r <= wb_dat_i[2:0];
      if (adr == OFS_VLIST)
        vlist_r <= wb_dat_i[1:0];
      if (adr == OFS_INT_MASK)
        mask_r <= wb_dat_i[1:0];
    end
  end

  // acknowledge marks active; completion clears it
  always_ff @(posedge clk_i) begin
    if (sys_rst_i)
      active_r <= '0;
    else if (ack_take)
      active_r[hp_id[PW-1:0]] <= 1'b1;
    else if (eoi_ok)
      active_r[eoi_ix] <= 1'b0;
  end

  // ************************************************************
  // Request lines and interrupt output
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      fast_irq_request_n_o     <= 1'b1;
      normal_irq_request_n_o   <= 1'b1;
      virtual_fast_request_o   <= 1'b0;
      virtual_normal_request_o <= 1'b0;
      stat_r                   <= 2'h0;
      irq_o                    <= 1'b0;
    end else begin
      fast_irq_request_n_o     <= !fast_nxt;
      normal_irq_request_n_o   <= !norm_nxt;
      // list entry shown to the guest as fast or normal
      virtual_fast_request_o   <= vlist_r[VL_PEND] && vlist_r[VL_FAST];
      virtual_normal_request_o <= vlist_r[VL_PEND] && !vlist_r[VL_FAST];
      stat_r                   <= stat_nxt;
      irq_o                    <= |(stat_nxt & mask_r);
    end
  end

endmodule

// *** bench/igr_props.sv ***
/* Port checker for igr_top.
   Assumes a bind from the bench top, one clock and a synchronous reset. */
`timescale 1ns/1ps
module igr_props #(
  parameter int NUM_IRQ = 32
) (
  input wire logic                       clk_i,
  input wire logic                       sys_rst_i,
  input wire logic                       wb_cyc_i,
  input wire logic                       wb_stb_i,
  input wire logic                       wb_we_i,
  input wire logic [igr_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0]                 wb_sel_i,
  input wire logic [31:0]                wb_dat_i,
  input wire logic [31:0]                wb_dat_o,
  input wire logic                       wb_ack_o,
  input wire logic [NUM_IRQ-1:0]         irq_src_i,
  input wire logic                       fast_irq_request_n_o,
  input wire logic                       normal_irq_request_n_o,
  input wire logic                       virtual_fast_request_o,
  input wire logic                       virtual_normal_request_o,
  input wire logic                       irq_o
);
  import igr_pkg::*;
  // ************************************************************
  // Helpers and properties
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Taken accesses; control writes need lane 0
  wire logic go    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire logic wr_go = go & wb_we_i & wb_sel_i[0];
  wire logic vf_x  = wb_dat_i[0] & wb_dat_i[1];
  wire logic vn_x  = wb_dat_i[0] & ~wb_dat_i[1];
  a_ack_latency: assert property (go |=> wb_ack_o) // CT1
    else $error("ack not one cycle after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) // CT2
    else $error("ack longer than one cycle");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) // CT3
    else $error("read data outside ack");
  a_unmapped_zero: assert property (go && !wb_we_i && wb_adr_i == 14'h3000 |=> wb_dat_o == 32'h0) // CT4
    else $error("unmapped read not zero");
  a_reset_quiet: assert property (disable iff (1'b0) sys_rst_i |=> fast_irq_request_n_o &&
    normal_irq_request_n_o && !virtual_fast_request_o && !virtual_normal_request_o && !irq_o)
    else $error("outputs not idle after reset");
  a_one_line: assert property (!(!fast_irq_request_n_o && !normal_irq_request_n_o))
    else $error("both request lines active");
  a_idle_sources: assert property ((irq_src_i == '0) [*5] |-> fast_irq_request_n_o && normal_irq_request_n_o)
    else $error("request without source");
  a_vlist_follow: assert property (wr_go && wb_adr_i == OFS_VLIST |-> ##2
    virtual_fast_request_o == $past(vf_x, 2) && virtual_normal_request_o == $past(vn_x, 2))
    else $error("virtual outputs do not follow list");
  a_mask_clear: assert property (wr_go && wb_adr_i == OFS_INT_MASK && wb_dat_i[1:0] == 2'b00 |-> ##2 !irq_o) // IT1
    else $error("irq while fully masked");
endmodule

// *** bench/igr_core_model.sv ***
/* Processor core model on the request lines.
   Assumes active-low levels; counts each exception entry it would take. */
`timescale 1ns/1ps
module igr_core_model (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       fast_n_i,
  input  wire logic       norm_n_i,
  output logic      [7:0] fiq_cnt_o,
  output logic      [7:0] irq_cnt_o
);
  logic fast_n_r;
  logic norm_n_r;
  // Entry on a falling request; a held level is one exception only
  always_ff @(posedge clk_i) begin
    fast_n_r <= sys_rst_i | fast_n_i;
    norm_n_r <= sys_rst_i | norm_n_i;
    if (sys_rst_i) begin
      fiq_cnt_o <= 8'h00;
      irq_cnt_o <= 8'h00;
    end else begin
      fiq_cnt_o <= fiq_cnt_o + 8'(fast_n_r & ~fast_n_i);
      irq_cnt_o <= irq_cnt_o + 8'(norm_n_r & ~norm_n_i);
    end
  end
endmodule

// *** bench/igr_top_test.sv ***
/* Self-checking bench for igr_top with a core model on the request lines.
   Assumes the package map and the one-cycle Wishbone answer of the design. */
`timescale 1ns/1ps
module igr_top_test;
  import igr_pkg::*;
  localparam int NORMAL_IRQ_REQUEST_N = 32;
  logic        clk_i = 1'b0, sys_rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [13:0] adr = 14'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, rd, seed = 32'hfa2a, sa, sb;
  logic [NORMAL_IRQ_REQUEST_N-1:0] src = '0;
  logic        fast_n, norm_n, vfast, vnorm, irq, ack;
  logic [7:0]  fiq_cnt, irq_cnt;
  logic [4:0]  a;
  int          failures = 0, cmp_count = 0, cycles = 0;
  igr_top #(.NUM_IRQ(NORMAL_IRQ_REQUEST_N)) igr_top_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_src_i(src),
    .fast_irq_request_n_o(fast_n), .normal_irq_request_n_o(norm_n),
    .virtual_fast_request_o(vfast), .virtual_normal_request_o(vnorm), .irq_o(irq));
  igr_core_model igr_core_model_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .fast_n_i(fast_n), .norm_n_i(norm_n), .fiq_cnt_o(fiq_cnt), .irq_cnt_o(irq_cnt));
  // ************************************************************
  // Clock, timeout and helpers
  // ************************************************************
  initial forever #4 clk_i = ~clk_i;
  // A hung handshake would stall the run; a few hundred accesses fit
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      give_verdict();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  // Classic cycle: held until ack is sampled, then released for a cycle
  task automatic wb(input logic w, input logic [13:0] ad, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= ad; wdat <= d; sel <= 4'hf;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task automatic wr(input logic [13:0] ad, input logic [31:0] d);
    wb(1'b1, ad, d);
  endtask
  task automatic rdc(input string nm, input logic [13:0] ad, input logic [31:0] exp);
    wb(1'b0, ad, 32'h0);
    chk(nm, exp, rd);
  endtask
  // Sync plus output flop is three edges; four leaves margin
  task automatic lines(input logic ef, input logic en);
    repeat (4) @(posedge clk_i);
    chk("fast_n", 32'(ef), 32'(fast_n));
    chk("norm_n", 32'(en), 32'(norm_n));
  endtask
  task automatic give_verdict();
    if (failures == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    lines(1'b1, 1'b1);
    rdc("group", OFS_GROUP, 32'h0);
    rdc("bin_pt", OFS_BIN_PT, {29'h0, BIN_PT_RST});
    rdc("abin_pt", OFS_ABIN_PT, {29'h0, ABIN_PT_RST});
    rdc("unmapped", 14'h3000, 32'h0); // CT4
    seed = lfsr(seed);
    a = {seed[2:0], 2'b00};
    sa = 32'h1 << a;
    sb = 32'h1 << (a + 5'h1);
    wr(OFS_ENABLE, seed);
    rdc("enable", OFS_ENABLE, seed); // CT5
    // Word holds a at 0x40 and its neighbour at 0x38
    wr(OFS_ENABLE, 32'hffffffff);
    wr(OFS_PRIO + 14'(a), 32'h3840);
    rdc("prio", OFS_PRIO + 14'(a), 32'h3840); // CT5
    wr(OFS_PRIO_MASK, 32'hff);
    wr(OFS_DIST_CTRL, 32'h3);
    wr(OFS_CPU_CTRL, 32'h0b);
    @(posedge clk_i);
    src <= sa;
    lines(1'b0, 1'b1);
    // The core model counts a fall one edge after the line shows it
    @(posedge clk_i);
    chk("fiq_cnt", 32'h1, 32'(fiq_cnt));
    rdc("hp_pend", OFS_HP_PEND, 32'(a));
    wr(OFS_CPU_CTRL, 32'h03);
    lines(1'b1, 1'b0);
    chk("irq_cnt", 32'h1, 32'(irq_cnt));
    wr(OFS_CPU_CTRL, 32'h0b);
    wr(OFS_GROUP, sa);
    lines(1'b1, 1'b0);
    wr(OFS_DIST_CTRL, 32'h1);
    lines(1'b1, 1'b1);
    wr(OFS_DIST_CTRL, 32'h3);
    wr(OFS_CPU_CTRL, 32'h09);
    lines(1'b1, 1'b1);
    wr(OFS_CPU_CTRL, 32'h0b);
    rdc("ack_grp1", OFS_ACK, {22'h0, ID_WRONG_GRP});
    rdc("aack", OFS_AACK, 32'(a));
    lines(1'b1, 1'b1);
    wr(OFS_EOI, 32'(a));
    rdc("run_prio", OFS_RUN_PRIO, 32'h40);
    wr(OFS_AEOI, 32'(a));
    rdc("run_prio", OFS_RUN_PRIO, 32'hff);
    wr(OFS_GROUP, 32'h0);
    rdc("ack_grp0", OFS_ACK, 32'(a));
    wr(OFS_EOI, 32'(a));
    rdc("run_prio", OFS_RUN_PRIO, 32'hff);
    wr(OFS_CPU_CTRL, 32'h0f);
    wr(OFS_GROUP, sa);
    rdc("ack_legacy", OFS_ACK, 32'(a));
    wr(OFS_EOI, 32'(a));
    rdc("run_prio", OFS_RUN_PRIO, 32'hff);
    // Sticky events from the wrong-group read and the bad completion
    rdc("status", OFS_INT_STAT, 32'h3); // IT2
    wr(OFS_INT_MASK, 32'h3);
    repeat (3) @(posedge clk_i);
    chk("irq", 32'h1, 32'(irq)); // IT1
    wr(OFS_INT_MASK, 32'h0);
    repeat (3) @(posedge clk_i);
    chk("irq", 32'h0, 32'(irq)); // IT1
    wr(OFS_INT_STAT, 32'h3);
    rdc("status", OFS_INT_STAT, 32'h0); // IT2
    for (int i = 0; i < 4; i++) begin
      wr(OFS_VLIST, 32'(i));
      repeat (2) @(posedge clk_i);
      chk("vfast", 32'(i == 3), 32'(vfast));
      chk("vnorm", 32'(i == 1), 32'(vnorm));
    end
    // Neighbour preempts a only through the aliased point
    wr(OFS_CPU_CTRL, 32'h03);
    wr(OFS_GROUP, sa | sb);
    rdc("aack", OFS_AACK, 32'(a));
    @(posedge clk_i);
    src <= sa | sb;
    wr(OFS_BIN_PT, 32'h6);
    lines(1'b1, 1'b0);
    wr(OFS_CPU_CTRL, 32'h13);
    lines(1'b1, 1'b1);
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    lines(1'b1, 1'b1);
    rdc("group", OFS_GROUP, 32'h0);
    give_verdict();
  end
endmodule
bind igr_top igr_props #(.NUM_IRQ(NUM_IRQ)) igr_props_inst (.clk_i(clk_i),
  .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .irq_src_i(irq_src_i), .fast_irq_request_n_o(fast_irq_request_n_o),
  .normal_irq_request_n_o(normal_irq_request_n_o),
  .virtual_fast_request_o(virtual_fast_request_o),
  .virtual_normal_request_o(virtual_normal_request_o), .irq_o(irq_o));
